// File: switch_onto_fault.sv
// Switch-onto-fault arming block with registers, events and records
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
module switch_onto_fault
    import fault_close_pkg::*;
#(
    parameter int N_FUNC = 4,
    parameter int CNT_W  = 16,
    parameter int MS_DIV = CYCLES_PER_MS
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              activate_di,
    input  wire logic              close_cmd,
    input  wire logic              block_in,
    input  wire logic [N_FUNC-1:0] function_in,
    input  wire logic [7:0]        addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [31:0]       rdata,
    output logic                   trip,
    output logic                   active,
    output logic [N_EV-1:0]        ev_valid,
    output logic                   ev_edge_on,
    output logic [31:0]            ev_stamp,
    output logic                   irq
);
    initial begin
        if (N_FUNC < 1) $error("switch_onto_fault: N_FUNC must be at least 1");
    end

    logic                 ms_tick;
    logic [31:0]          stamp_ms;
    logic [N_EV*CNT_W-1:0] counts;
    logic [N_EV-1:0]      cnt_clr;

    ms_timebase #(.DIV(MS_DIV)) u_tb (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .ms_tick  (ms_tick),
        .stamp_ms (stamp_ms)
    );

    // Control registers
    logic [2:0]  mode_reg;
    logic        force_en_reg;
    logic [1:0]  force_reg;
    logic [1:0]  evsel_reg;
    logic [1:0]  sg_reg;
    logic [20:0] release_reg;
    logic [N_EV-1:0] irq_mask_reg;
    logic [3:0]  rec_sel_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg     <= MODE_ON;
            force_en_reg <= 1'b0;
            force_reg    <= FORCE_NORMAL;
            evsel_reg    <= EVSEL_BOTH;
            sg_reg       <= SG_RESET;
            release_reg  <= RELEASE_RESET_MS;
            irq_mask_reg <= '0;
            rec_sel_reg  <= 4'h0;
        end else if (wr_en) begin
            if (addr == ADDR_CTRL) begin
                if (wdata[CTRL_MODE_LSB +: 3] <= MODE_OFF)
                    mode_reg <= wdata[CTRL_MODE_LSB +: 3];
                force_en_reg <= wdata[CTRL_FORCE_EN];
                force_reg    <= wdata[CTRL_FORCE_LSB +: 2];
                evsel_reg    <= wdata[CTRL_EVSEL_LSB +: 2];
                sg_reg       <= wdata[CTRL_SG_LSB +: 2];
            end else if (addr == ADDR_RELEASE) begin
                // Out-of-range values saturate at the top of the range
                if (wdata > 32'(RELEASE_MAX_MS))
                    release_reg <= 21'(RELEASE_MAX_MS);
                else
                    release_reg <= wdata[20:0];
            end else if (addr == ADDR_IRQ_MASK) begin
                irq_mask_reg <= wdata[N_EV-1:0];
            end else if (addr == ADDR_REC_SEL) begin
                rec_sel_reg <= wdata[3:0];
            end
        end
    end

    assign cnt_clr = (wr_en && addr == ADDR_CNT_CLR) ? wdata[N_EV-1:0] : '0;

    // Mode qualification: Blocked, Test/Blocked and Off keep the window shut
    logic mode_blocks;
    assign mode_blocks = (mode_reg == MODE_BLOCKED) || (mode_reg == MODE_TEST_BLK)
                       || (mode_reg == MODE_OFF);

    // Activation edge detection on binary inputs only
    logic act_src;
    logic act_prev_reg;
    logic act_rise;
    logic func_any;
    logic blocked;
    assign act_src  = activate_di | close_cmd;
    assign act_rise = act_src & ~act_prev_reg;
    assign func_any = |function_in;
    assign blocked  = block_in | mode_blocks;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) act_prev_reg <= 1'b0;
        else        act_prev_reg <= act_src;
    end

    // Window timer, milliseconds elapsed since arming
    arm_state_t  state_reg;
    logic [20:0] elapsed_reg;
    logic        expire;
    // A live setting change is compared against directly, so it takes hold at once
    assign expire = (elapsed_reg >= release_reg);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (act_rise && !blocked && release_reg != 21'h0)
                        state_reg <= ST_ARMED;
                end
                ST_ARMED: begin
                    if (blocked || expire) state_reg <= ST_IDLE;
                    else if (func_any)     state_reg <= ST_TRIP;
                end
                ST_TRIP: begin
                    if (blocked || expire) state_reg <= ST_IDLE;
                    else if (!func_any)    state_reg <= ST_ARMED;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)                   elapsed_reg <= 21'h0;
        else if (state_reg == ST_IDLE) elapsed_reg <= 21'h0;
        else if (ms_tick && !expire)  elapsed_reg <= elapsed_reg + 21'h1;
    end

    // Status derivation; forcing overrides the computed status
    logic win_run;
    logic trip_now;
    logic [N_EV-1:0] st_now;
    logic [N_EV-1:0] st_prev_reg;
    condition_t cond_now;
    assign win_run = (state_reg != ST_IDLE) && !expire && !blocked;
    // Trip follows the function input combinationally through one flop
    assign trip_now = win_run && func_any;

    always_comb begin
        st_now = '0;
        if (force_en_reg) begin
            case (force_reg)
                FORCE_BLOCKED: st_now[EV_BLOCK] = 1'b1;
                FORCE_ACTIVE:  st_now[EV_ACT]   = 1'b1;
                FORCE_TRIP:    st_now[EV_TRIP]  = 1'b1;
                default:       st_now = '0;
            endcase
        end else begin
            st_now[EV_INIT]  = act_src && !blocked;
            st_now[EV_BLOCK] = blocked;
            st_now[EV_ACT]   = win_run;
            st_now[EV_TRIP]  = trip_now;
        end
    end

    always_comb begin
        if (st_now[EV_TRIP])       cond_now = COND_TRIP;
        else if (st_now[EV_ACT])   cond_now = COND_ACTIVE;
        else if (st_now[EV_BLOCK]) cond_now = COND_BLOCKED;
        else if (st_now[EV_INIT])  cond_now = COND_INIT;
        else                       cond_now = COND_NORMAL;
    end

    logic [2:0] cond_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_prev_reg <= '0;
            cond_reg    <= COND_NORMAL;
            trip        <= 1'b0;
            active      <= 1'b0;
        end else begin
            st_prev_reg <= st_now;
            cond_reg    <= cond_now;
            trip        <= st_now[EV_TRIP];
            active      <= st_now[EV_ACT];
        end
    end

    // Event edges and selection for the main buffer
    logic [N_EV-1:0] on_edge;
    logic [N_EV-1:0] off_edge;
    logic [N_EV-1:0] sel_ev;
    logic            sel_on;
    assign on_edge  = st_now & ~st_prev_reg;
    assign off_edge = ~st_now & st_prev_reg;
    always_comb begin
        case (evsel_reg)
            EVSEL_ON:  sel_ev = on_edge;
            EVSEL_OFF: sel_ev = off_edge;
            default:   sel_ev = on_edge | off_edge;
        endcase
        sel_on = |(sel_ev & on_edge);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_valid   <= '0;
            ev_edge_on <= 1'b0;
            ev_stamp   <= 32'h0;
        end else begin
            ev_valid   <= sel_ev;
            ev_edge_on <= sel_on;
            ev_stamp   <= stamp_ms;
        end
    end

    status_event_counters #(.W(CNT_W)) u_cnt (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .on_pulse (on_edge),
        .clr      (cnt_clr),
        .count    (counts)
    );

    // Sticky interrupt status; hardware set wins over read clear
    logic [N_EV-1:0] irq_stat_reg;
    logic            stat_rd;
    assign stat_rd = rd_en && addr == ADDR_IRQ_STAT;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)       irq_stat_reg <= '0;
        else if (stat_rd) irq_stat_reg <= on_edge;
        else              irq_stat_reg <= irq_stat_reg | on_edge;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) irq <= 1'b0;
        else        irq <= |(irq_stat_reg & irq_mask_reg & ~(stat_rd ? irq_stat_reg : '0))
                           || |(on_edge & irq_mask_reg);
    end

    // Operation record ring, written on each activation ON edge
    logic [31:0] rec_time [REC_DEPTH];
    logic [1:0]  rec_sg   [REC_DEPTH];
    logic [20:0] rec_rem  [REC_DEPTH];
    logic [20:0] rec_elap [REC_DEPTH];
    logic [3:0]  rec_wp_reg;
    logic [3:0]  rec_cnt_reg;
    logic        rec_wr;
    assign rec_wr = on_edge[EV_ACT];

    always_ff @(posedge ref_clk) begin
        if (rec_wr) begin
            rec_time[rec_wp_reg] <= stamp_ms;
            rec_sg[rec_wp_reg]   <= sg_reg;
            rec_rem[rec_wp_reg]  <= release_reg - elapsed_reg;
            rec_elap[rec_wp_reg] <= elapsed_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_wp_reg  <= 4'h0;
            rec_cnt_reg <= 4'h0;
        end else if (rec_wr) begin
            rec_wp_reg <= (rec_wp_reg == 4'(REC_DEPTH - 1)) ? 4'h0 : rec_wp_reg + 4'h1;
            if (rec_cnt_reg != 4'(REC_DEPTH)) rec_cnt_reg <= rec_cnt_reg + 4'h1;
        end
    end

    // Selected record, 0 = newest
    logic [3:0] rec_idx;
    logic       rec_ok;
    always_comb begin
        rec_ok  = (rec_sel_reg < rec_cnt_reg);
        rec_idx = (rec_wp_reg > rec_sel_reg) ? rec_wp_reg - rec_sel_reg - 4'h1
                : 4'(REC_DEPTH) + rec_wp_reg - rec_sel_reg - 4'h1;
        if (!rec_ok) rec_idx = 4'h0;
    end

    // Read mux; unmapped addresses read as zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (addr == ADDR_CTRL)
            rd_mux = {18'h0, sg_reg, 2'h0, evsel_reg, 1'b0, force_reg, force_en_reg, 1'b0,
                      mode_reg};
        else if (addr == ADDR_RELEASE)  rd_mux = {11'h0, release_reg};
        else if (addr == ADDR_STATUS)   rd_mux = {16'h0, 4'h0, st_now, 1'b0, mode_reg, 1'b0,
                                                  cond_reg};
        else if (addr == ADDR_IRQ_STAT) rd_mux = {28'h0, irq_stat_reg};
        else if (addr == ADDR_IRQ_MASK) rd_mux = {28'h0, irq_mask_reg};
        else if (addr == ADDR_CNT_INIT) rd_mux = 32'(counts[EV_INIT*CNT_W +: CNT_W]);
        else if (addr == ADDR_CNT_BLK)  rd_mux = 32'(counts[EV_BLOCK*CNT_W +: CNT_W]);
        else if (addr == ADDR_CNT_ACT)  rd_mux = 32'(counts[EV_ACT*CNT_W +: CNT_W]);
        else if (addr == ADDR_CNT_TRIP) rd_mux = 32'(counts[EV_TRIP*CNT_W +: CNT_W]);
        else if (addr == ADDR_REC_SEL)  rd_mux = {28'h0, rec_sel_reg};
        else if (addr == ADDR_REC_TIME && rec_ok) rd_mux = rec_time[rec_idx];
        else if (addr == ADDR_REC_INFO && rec_ok) rd_mux = {28'h0, 2'h0, rec_sg[rec_idx]};
        else if (addr == ADDR_REC_REM && rec_ok)  rd_mux = {11'h0, rec_rem[rec_idx]};
        else if (addr == ADDR_REC_ELAP && rec_ok) rd_mux = {11'h0, rec_elap[rec_idx]};
        else if (addr == ADDR_REC_CNT)  rd_mux = {28'h0, rec_cnt_reg};
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)     rdata <= 32'h0;
        else if (rd_en) rdata <= rd_mux;
        else            rdata <= 32'h0;
    end

    // Checks
    property p_arm_edge;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_IDLE && !(act_rise && !blocked && release_reg != 21'h0))
            |=> state_reg == ST_IDLE;
    endproperty
    a_arm_edge: assert property (p_arm_edge) else $error("window armed without edge");

    property p_block;
        @(posedge ref_clk) disable iff (!rst_n)
        block_in |=> state_reg == ST_IDLE;
    endproperty
    a_block: assert property (p_block) else $error("window running while blocked");

    property p_trip_fast;
        @(posedge ref_clk) disable iff (!rst_n)
        (win_run && func_any && !force_en_reg) |=> trip;
    endproperty
    a_trip_fast: assert property (p_trip_fast) else $error("trip not raised at once");

    property p_trip_drop;
        @(posedge ref_clk) disable iff (!rst_n)
        (!func_any && !force_en_reg) |=> !trip;
    endproperty
    a_trip_drop: assert property (p_trip_drop) else $error("trip held without function");

    sequence s_idle_rise;
        state_reg == ST_IDLE && act_rise && !blocked && release_reg != 21'h0;
    endsequence
    property p_arm_seq;
        @(posedge ref_clk) disable iff (!rst_n)
        s_idle_rise |=> state_reg == ST_ARMED && elapsed_reg == 21'h0;
    endproperty
    a_arm_seq: assert property (p_arm_seq) else $error("edge did not arm window");

    property p_expire;
        @(posedge ref_clk) disable iff (!rst_n)
        // A live shortening of the release time ends the window one cycle later
        (elapsed_reg > release_reg) |=> state_reg == ST_IDLE;
    endproperty
    a_expire: assert property (p_expire) else $error("window ran past release");

    property p_ev_on;
        @(posedge ref_clk) disable iff (!rst_n)
        (evsel_reg == EVSEL_ON && !$rose(trip)) |=> !ev_valid[EV_TRIP] || ev_edge_on;
    endproperty
    a_ev_on: assert property (p_ev_on) else $error("off event stored in on mode");

    property p_mode_off;
        @(posedge ref_clk) disable iff (!rst_n)
        (mode_reg == MODE_OFF) |=> state_reg == ST_IDLE;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("window ran in off mode");

    property p_rec_cnt;
        @(posedge ref_clk) disable iff (!rst_n)
        rec_cnt_reg <= 4'(REC_DEPTH);
    endproperty
    a_rec_cnt: assert property (p_rec_cnt) else $error("record count overflow");
endmodule

// File: switch_onto_fault_pkg.sv
// Package for the switch-onto-fault arming block
package fault_close_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_RELEASE  = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_CNT_INIT = 8'h14;
    localparam logic [7:0] ADDR_CNT_BLK  = 8'h18;
    localparam logic [7:0] ADDR_CNT_ACT  = 8'h1c;
    localparam logic [7:0] ADDR_CNT_TRIP = 8'h20;
    localparam logic [7:0] ADDR_CNT_CLR  = 8'h24;
    localparam logic [7:0] ADDR_REC_SEL  = 8'h28;
    localparam logic [7:0] ADDR_REC_TIME = 8'h2c;
    localparam logic [7:0] ADDR_REC_INFO = 8'h30;
    localparam logic [7:0] ADDR_REC_REM  = 8'h34;
    localparam logic [7:0] ADDR_REC_ELAP = 8'h38;
    localparam logic [7:0] ADDR_REC_CNT  = 8'h3c;
    // Control register fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_FORCE_EN  = 4;
    localparam int CTRL_FORCE_LSB = 5;
    localparam int CTRL_EVSEL_LSB = 8;
    localparam int CTRL_SG_LSB    = 12;
    // Release time in milliseconds, clock timing and record depth
    localparam int          RELEASE_MAX_MS   = 1800000;
    localparam logic [20:0] RELEASE_RESET_MS = 21'h0003e8;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          MS_NS            = 1000000;
    localparam int          CYCLES_PER_MS    = MS_NS / CLK_PERIOD_NS;
    localparam int          REC_DEPTH        = 12;
    // Event selection codes and the SG reset value
    localparam logic [1:0] EVSEL_BOTH = 2'h0;
    localparam logic [1:0] EVSEL_ON   = 2'h1;
    localparam logic [1:0] EVSEL_OFF  = 2'h2;
    localparam logic [1:0] SG_RESET   = 2'h0;

    typedef enum logic [2:0] {
        MODE_ON       = 3'h0,
        MODE_BLOCKED  = 3'h1,
        MODE_TEST     = 3'h2,
        MODE_TEST_BLK = 3'h3,
        MODE_OFF      = 3'h4
    } node_operating_mode_t;

    typedef enum logic [1:0] {
        FORCE_NORMAL  = 2'h0,
        FORCE_BLOCKED = 2'h1,
        FORCE_ACTIVE  = 2'h2,
        FORCE_TRIP    = 2'h3
    } force_t;

    typedef enum logic [2:0] {
        COND_NORMAL  = 3'h0,
        COND_INIT    = 3'h1,
        COND_ACTIVE  = 3'h2,
        COND_TRIP    = 3'h3,
        COND_BLOCKED = 3'h4
    } condition_t;

    // Arming state machine, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_TRIP  = 3'b100
    } arm_state_t;

    // Event bit positions: init, block, active, trip
    localparam int EV_INIT  = 0;
    localparam int EV_BLOCK = 1;
    localparam int EV_ACT   = 2;
    localparam int EV_TRIP  = 3;
    localparam int N_EV     = 4;
endpackage

// File: switch_onto_fault_timebase.sv
// Millisecond tick and free-running millisecond timestamp
`timescale 1ns/1ps
module ms_timebase
    import fault_close_pkg::*;
#(
    parameter int DIV = CYCLES_PER_MS
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    output logic             ms_tick,
    output logic [31:0]      stamp_ms
);
    initial begin
        if (DIV < 1) $error("ms_timebase: DIV must be at least 1");
    end

    logic [31:0] div_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 32'h0;
            ms_tick <= 1'b0;
        end else if (div_reg >= 32'(DIV - 1)) begin
            div_reg <= 32'h0;
            ms_tick <= 1'b1;
        end else begin
            div_reg <= div_reg + 32'h1;
            ms_tick <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stamp_ms <= 32'h0;
        end else if (ms_tick) begin
            stamp_ms <= stamp_ms + 32'h1;
        end
    end
endmodule

// File: switch_onto_fault_event_counters.sv
// Resettable cumulative counters of the four status events
`timescale 1ns/1ps
module status_event_counters
    import fault_close_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic [N_EV-1:0]      on_pulse,
    input  wire logic [N_EV-1:0]      clr,
    output logic      [N_EV*W-1:0]    count
);
    initial begin
        if (W < 1 || W > 32) $error("status_event_counters: W out of range");
    end

    // An ON edge in the clearing cycle still counts once
    for (genvar i = 0; i < N_EV; i++) begin : g_cnt
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                count[i*W +: W] <= '0;
            end else if (clr[i]) begin
                count[i*W +: W] <= W'(on_pulse[i]);
            end else if (on_pulse[i]) begin
                count[i*W +: W] <= count[i*W +: W] + W'(1);
            end
        end
    end
endmodule

// File: far_side_model.sv
// Far-side model: breaker close command and protection start outputs
`timescale 1ns/1ps
module far_side_model #(
    parameter int N = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         close_req,
    input  wire logic [N-1:0] start_req,
    output logic              close_cmd,
    output logic      [N-1:0] function_in
);
    // Registered like real relay logic, so every command lands one cycle late
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            close_cmd   <= 1'b0;
            function_in <= '0;
        end else begin
            close_cmd   <= close_req;
            function_in <= start_req;
        end
    end
endmodule

// File: testbench.sv
// Self-checking testbench for the switch-onto-fault block
`timescale 1ns/1ps
module testbench;
    import fault_close_pkg::*;
    logic        ref_clk, rst_n, activate_di, block_in, close_req, close_cmd;
    logic        wr_en, rd_en, trip, active, ev_edge_on, irq;
    logic [3:0]  start_req, function_in, ev_valid;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, ev_stamp, rv;
    int          n_mismatch, checks_done, n_on, n_off;

    far_side_model #(.N(4)) far (.ref_clk(ref_clk), .rst_n(rst_n), .close_req(close_req),
        .start_req(start_req), .close_cmd(close_cmd), .function_in(function_in));
    switch_onto_fault #(.N_FUNC(4), .CNT_W(16), .MS_DIV(10)) DUT (.ref_clk(ref_clk),
        .rst_n(rst_n), .activate_di(activate_di), .close_cmd(close_cmd), .block_in(block_in),
        .function_in(function_in), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .trip(trip), .active(active), .ev_valid(ev_valid),
        .ev_edge_on(ev_edge_on), .ev_stamp(ev_stamp), .irq(irq));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Edge-direction tally of Active events as they leave the block
    always @(posedge ref_clk) begin
        if (ev_valid[EV_ACT] === 1'b1) begin
            if (ev_edge_on) n_on++;
            else n_off++;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a; wdata <= d; wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a; rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 rv = rdata;
    endtask
    task arm(input bit di);
        @(posedge ref_clk);
        if (di) activate_di <= 1'b1;
        else close_req <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask
    // Window is 3 ms of 10-cycle ticks, so 50 cycles always outlast it
    task disarm;
        @(posedge ref_clk);
        activate_di <= 1'b0; close_req <= 1'b0;
        repeat (50) @(posedge ref_clk);
        #1;
    endtask
    task fault(input logic [3:0] f);
        @(posedge ref_clk);
        start_req <= f;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task t_reset;
        rd(ADDR_CTRL);   chk(rv, 32'h0);
        rd(ADDR_RELEASE); chk(rv, {11'h0, RELEASE_RESET_MS});
        rd(ADDR_STATUS); chk(rv[2:0], COND_NORMAL);
        rd(8'h40);       chk(rv, 32'h0);
    endtask
    task t_trip;
        wr(ADDR_RELEASE, 32'h3); wr(ADDR_IRQ_MASK, 32'h4);
        arm(0); chk(active, 1'b1);
        chk(irq, 1'b1);
        fault(4'h4); chk(trip, 1'b1);
        rd(ADDR_STATUS); chk(rv[2:0], COND_TRIP);
        fault(4'h0); chk(trip, 1'b0);
        disarm; chk(active, 1'b0);
        rd(ADDR_IRQ_STAT); rd(ADDR_IRQ_STAT); chk(rv, 32'h0);
        chk(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h0);
    endtask
    task t_level_block;
        arm(1); repeat (50) @(posedge ref_clk);
        #1 chk(active, 1'b0);
        disarm;
        block_in <= 1'b1;
        arm(1); chk(active, 1'b0);
        fault(4'h1); chk(trip, 1'b0);
        fault(4'h0); disarm; block_in <= 1'b0;
    endtask
    task t_modes;
        for (int m = 0; m < 5; m++) begin
            wr(ADDR_CTRL, m); rd(ADDR_STATUS); chk(rv[6:4], m);
            arm(1); chk(active, m == 0 || m == 2);
            disarm;
        end
        wr(ADDR_CTRL, 32'h0);
    endtask
    task t_counters;
        rd(ADDR_CNT_ACT); chk(rv, 32'h4);
        rd(ADDR_CNT_TRIP); chk(rv, 32'h1);
        wr(ADDR_CNT_CLR, 32'hf); rd(ADDR_CNT_ACT); chk(rv, 32'h0);
    endtask
    task t_record;
        n_on = 0; n_off = 0;
        wr(ADDR_CTRL, 32'h2100); wr(ADDR_RELEASE, 32'h3e8);
        arm(0); wr(ADDR_RELEASE, 32'h2);
        disarm; chk(active, 1'b0);
        chk(n_on, 1); chk(n_off, 0);
        wr(ADDR_REC_SEL, 32'h0);
        rd(ADDR_REC_INFO); chk(rv[1:0], 2'h2);
        rd(ADDR_REC_REM); chk(rv, 32'h3e8);
    endtask
    task t_force;
        wr(ADDR_CTRL, 32'h70); repeat (2) @(posedge ref_clk);
        #1 chk(trip, 1'b1);
        wr(ADDR_CTRL, 32'h0); repeat (2) @(posedge ref_clk);
        #1 chk(trip, 1'b0);
    endtask

    // Whole run is well under 2000 cycles; this only catches a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        end_sim;
    end
    initial begin
        rst_n = 1'b0; activate_di = 1'b0; block_in = 1'b0; close_req = 1'b0;
        start_req = 4'h0; addr = 8'h0; wdata = 32'h0; wr_en = 1'b0; rd_en = 1'b0;
        n_mismatch = 0; checks_done = 0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset; t_trip; t_level_block; t_modes; t_counters; t_record; t_force;
        end_sim;
    end
endmodule
